// ---- test_watchdog_bus_control_regs.sv ----
// Self-checking bench for the watchdog and bus control register bank.
`timescale 1ns/1ns
`include "wbc_regs_map.vh"

module test_watchdog_bus_control_regs;
  reg        clk, rst_n, cfgPin, softReset, restart, stopMode, sleepMode, busWake, hwWrite;
  reg  [6:0] hwAddr;
  reg  [7:0] hwData, rd;
  reg  [2:0] p;
  reg  [1:0] m;
  integer    c, mismatches, num_checks, failCnt, wakeCnt, cycles;
  wire       spiCs_n, spiSclk, spiMosi, spiMiso, spiFail, boostLowSel, boostEnable;
  wire       failoutSecondTrip, failSafeOnWdtFail, wdtActive, wdtWindowSel, wdtPeriodValid;
  wire       wdtLongWindowStart, wdtMaxThreeResets, linFlashMode, lowSlopeSel, txTimeoutEn;
  wire [2:0] wdtPeriod;
  wire [1:0] canMode, linChAMode, linChBMode, linChCMode, linChDMode;
  wire       spiMisoOe;

  wbc_regs     dut_u  (.clk(clk), .rst_n(rst_n), .spiCs_n(spiCs_n), .spiSclk(spiSclk),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .cfgPin(cfgPin),
    .softReset(softReset), .restart(restart), .stopMode(stopMode), .sleepMode(sleepMode),
    .busWake(busWake), .hwWrite(hwWrite), .hwAddr(hwAddr), .hwData(hwData),
    .spiFail(spiFail), .boostLowSel(boostLowSel), .boostEnable(boostEnable),
    .failoutSecondTrip(failoutSecondTrip), .failSafeOnWdtFail(failSafeOnWdtFail),
    .wdtActive(wdtActive), .wdtWindowSel(wdtWindowSel),
    .wdtLongWindowStart(wdtLongWindowStart), .wdtMaxThreeResets(wdtMaxThreeResets),
    .wdtPeriod(wdtPeriod), .wdtPeriodValid(wdtPeriodValid), .linFlashMode(linFlashMode),
    .lowSlopeSel(lowSlopeSel), .txTimeoutEn(txTimeoutEn), .canMode(canMode),
    .linChAMode(linChAMode), .linChBMode(linChBMode), .linChCMode(linChCMode),
    .linChDMode(linChDMode));
  wbc_spi_host host_u (.clk(clk), .spiMiso(spiMiso), .spiCs_n(spiCs_n),
    .spiSclk(spiSclk), .spiMosi(spiMosi));

  // ----------------------------------------------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Pulses are one cycle wide, so they are tallied here rather than polled.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (spiFail === 1'b1) failCnt = failCnt + 1;
    if (wdtLongWindowStart === 1'b1) wakeCnt = wakeCnt + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      results;
    end
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    host_u.frame({d, 1'b1, a}, 16, rd);
  endtask
  task rdchk(input [6:0] a, input [7:0] e);
    begin
      host_u.frame({8'h00, 1'b0, a}, 16, rd);
      chk("readback", rd, e);
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {rst_n, cfgPin, softReset, restart, stopMode, sleepMode, busWake, hwWrite} = 8'h00;
    {hwAddr, hwData} = 15'h0000;
    {mismatches, num_checks, failCnt, wakeCnt, cycles} = 0;
    idle(3);
    rst_n = 1'b1;
    idle(4);
    chk("spiMisoOe", spiMisoOe, 1'b0);
    rdchk(`WBC_ADDR_WDT_CTRL, 8'h14);
    rdchk(`WBC_ADDR_BUS_ONE, 8'h20);
    rdchk(`WBC_ADDR_BUS_TWO, 8'h00);
    $display("test reset values done");
    wr(`WBC_ADDR_HW_CTRL, 8'h07);
    chk("hw", {boostLowSel, boostEnable, failoutSecondTrip}, 3'h6);
    wr(`WBC_ADDR_HW_CTRL, 8'h00);
    cfgPin = 1'b1;
    idle(6);
    chk("hw", {boostLowSel, boostEnable, failoutSecondTrip, failSafeOnWdtFail}, 4'h3);
    $display("test hardware control done");
    wr(`WBC_ADDR_WDT_CTRL, 8'hff);
    rdchk(`WBC_ADDR_WDT_CTRL, 8'h7f);
    chk("wdt", {wdtWindowSel, wdtMaxThreeResets, wdtPeriodValid, wdtPeriod}, 6'h37);
    wr(`WBC_ADDR_WDT_CTRL, 8'hfe);
    rdchk(`WBC_ADDR_WDT_CTRL, 8'h7f);
    chk("failCnt", failCnt, 1);
    stopMode = 1'b1;
    idle(4);
    busWake = 1'b1;
    idle(1);
    busWake = 1'b0;
    idle(3);
    chk("stop", {wdtActive, wakeCnt[3:0]}, 5'h01);
    stopMode = 1'b0;
    // Even parity over the byte is formed by the host for each period code from 0 to 6.
    for (c = 0; c < 7; c = c + 1) begin
      p = c;
      wr(`WBC_ADDR_WDT_CTRL, {^p, 4'h0, p});
      chk("wdtPeriod", {wdtPeriodValid, wdtPeriod}, {1'b1, p});
    end
    stopMode = 1'b1;
    idle(3);
    busWake = 1'b1;
    idle(1);
    busWake = 1'b0;
    idle(3);
    chk("stop", {wdtActive, wakeCnt[3:0]}, 5'h11);
    stopMode = 1'b0;
    $display("test watchdog control done");
    wr(`WBC_ADDR_BUS_ONE, 8'hff);
    rdchk(`WBC_ADDR_BUS_ONE, 8'hfb);
    chk("busOne", {linFlashMode, lowSlopeSel, txTimeoutEn, canMode, linChAMode}, 7'h7f);
    for (c = 0; c < 4; c = c + 1) begin
      m = c;
      wr(`WBC_ADDR_BUS_TWO, {m, 1'b1, m, 1'b1, m});
      rdchk(`WBC_ADDR_BUS_TWO, {m, 1'b0, m, 1'b0, m});
      chk("busTwo", {linChBMode, linChCMode, linChDMode}, {m, m, m});
    end
    stopMode = 1'b1;
    idle(4);
    chk("lp", {canMode, linChAMode, linChBMode, linChCMode, linChDMode}, 10'h155);
    rdchk(`WBC_ADDR_BUS_TWO, 8'hdb);
    wr(`WBC_ADDR_BUS_TWO, 8'h92);
    chk("lp", {linChBMode, linChCMode, linChDMode}, 6'h2a);
    stopMode = 1'b0;
    wr(`WBC_ADDR_BUS_ONE, 8'hf9);
    sleepMode = 1'b1;
    idle(4);
    chk("sleep", {canMode, linChAMode}, 4'h5);
    sleepMode = 1'b0;
    idle(4);
    chk("resume", {canMode, linChAMode}, 4'h7);
    $display("test bus control done");
    {hwAddr, hwData, hwWrite} = {`WBC_ADDR_BUS_TWO, 8'hff, 1'b1};
    idle(1);
    hwWrite = 1'b0;
    rdchk(`WBC_ADDR_BUS_TWO, 8'hdb);
    host_u.frame({8'h00, 1'b1, `WBC_ADDR_BUS_ONE}, 15, rd);
    rdchk(`WBC_ADDR_BUS_ONE, 8'hf9);
    host_u.frame({8'h00, 1'b1, `WBC_ADDR_BUS_ONE}, 32, rd);
    rdchk(`WBC_ADDR_BUS_ONE, 8'hf9);
    wr(7'h10, 8'hff);
    rdchk(7'h10, 8'h00);
    $display("test device update and refusals done");
    wr(`WBC_ADDR_WDT_CTRL, 8'hff);
    restart = 1'b1;
    idle(1);
    restart = 1'b0;
    rdchk(`WBC_ADDR_WDT_CTRL, 8'h14);
    rdchk(`WBC_ADDR_BUS_ONE, 8'hf9);
    rdchk(`WBC_ADDR_BUS_TWO, 8'hdb);
    // Wake restart is armed again, but a wake outside Stop must not start it.
    busWake = 1'b1;
    idle(1);
    busWake = 1'b0;
    idle(3);
    chk("wakeCnt", wakeCnt, 1);
    softReset = 1'b1;
    idle(1);
    softReset = 1'b0;
    rdchk(`WBC_ADDR_BUS_ONE, 8'h20);
    rdchk(`WBC_ADDR_BUS_TWO, 8'h00);
    $display("test restart and soft reset done");
    results;
  end
endmodule

// ---- wbc_regs.v ----
// SPI reachable hardware, watchdog and bus control registers with their decoded outputs.
//
// Behaviour
// RULE1: Hardware bit 2 picks 6.65 V boost.
// RULE2: Hardware bit 1 enables the automatic boost.
// RULE3: Hardware bit 0 clear: fail after second trip.
// RULE4: Config pin chooses fail-safe with supply off.
// RULE5: Watchdog write needs even parity, else fail.
// RULE6: Watchdog parity bit always reads zero.
// RULE7: Watchdog bit 6 stops watchdog in Stop.
// RULE8: Watchdog bit 5 selects window watchdog.
// RULE9: Watchdog bit 4 restarts it on bus wake.
// RULE10: Watchdog bit 3 limits resets to three.
// RULE11: Period code picks 10 ms to 1 s.
// RULE12: Bus one bit 7 disables slope, flash.
// RULE13: Bus one bit 6 selects low slope.
// RULE14: Bus one bit 5 enables transmit time-out.
// RULE15: Two-bit fields give off, wake, receive, normal.
// RULE16: Reserved bus bits read as zero.
// RULE17: Normal acts as wake in Stop, Sleep.
// RULE18: Host sets receive-only before Stop itself.
// RULE19: Host parks CAN before commanding Sleep.
// RULE20: Watchdog byte reset and restart values.
// RULE21: Bus one reset and restart values.
// RULE22: Bus two reset and restart values.
// RULE23: Device logic may change hardware-typed bits.
// RULE24: Frame is address, access bit, data byte.
`timescale 1ns/1ns
`include "wbc_regs_map.vh"

module wbc_regs (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       spiCs_n,
  input  wire       spiSclk,
  input  wire       spiMosi,
  output reg        spiMiso,
  output wire       spiMisoOe,
  input  wire       cfgPin,
  input  wire       softReset,
  input  wire       restart,
  input  wire       stopMode,
  input  wire       sleepMode,
  input  wire       busWake,
  input  wire       hwWrite,
  input  wire [6:0] hwAddr,
  input  wire [7:0] hwData,
  output reg        spiFail,
  output reg        boostLowSel,
  output reg        boostEnable,
  output reg        failoutSecondTrip,
  output reg        failSafeOnWdtFail,
  output reg        wdtActive,
  output reg        wdtWindowSel,
  output reg        wdtLongWindowStart,
  output reg        wdtMaxThreeResets,
  output reg  [2:0] wdtPeriod,
  output reg        wdtPeriodValid,
  output reg        linFlashMode,
  output reg        lowSlopeSel,
  output reg        txTimeoutEn,
  output reg  [1:0] canMode,
  output reg  [1:0] linChAMode,
  output reg  [1:0] linChBMode,
  output reg  [1:0] linChCMode,
  output reg  [1:0] linChDMode
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [1:0]  csSync;
  reg [1:0]  sclkSync;
  reg [1:0]  mosiSync;
  reg        csLast;
  reg        sclkLast;
  reg        cfgMeta;
  reg        cfgSync;
  reg [3:0]  bitCnt;
  reg [15:0] frame;
  reg [7:0]  txByte;
  reg [7:0]  hwCtrl;
  reg [7:0]  wdtCtrl;
  reg [7:0]  busOne;
  reg [7:0]  busTwo;
  reg [7:0]  readData;

  wire       csActive  = ~csSync[1];
  wire       sclkRise  = sclkSync[1] & ~sclkLast;
  wire       sclkFall  = ~sclkSync[1] & sclkLast;
  wire       frameEnd  = csSync[1] & ~csLast;
  wire       lowPower  = stopMode | sleepMode;
  wire [6:0] rxAddr    = frame[6:0];
  wire [7:0] rxData    = frame[15:`WBC_DATA_LSB];
  wire       fullFrame = frame[`WBC_ACCESS_BIT];
  wire       parityOk  = ~(^rxData);

  // Every pin passes two flops; only the second stage and later are read.
  always @(posedge clk) begin
    if (!rst_n) begin
      csSync   <= 2'h3;
      sclkSync <= 2'h0;
      mosiSync <= 2'h0;
      csLast   <= 1'b1;
      sclkLast <= 1'b0;
      cfgMeta  <= 1'b0;
      cfgSync  <= 1'b0;
    end else begin
      csSync   <= {csSync[0], spiCs_n};
      sclkSync <= {sclkSync[0], spiSclk};
      mosiSync <= {mosiSync[0], spiMosi};
      csLast   <= csSync[1];
      sclkLast <= sclkSync[1];
      cfgMeta  <= cfgPin;
      cfgSync  <= cfgMeta;
    end
  end

  // --------------------------------------------------------------------------
  // Frame shifter
  // --------------------------------------------------------------------------
  // Bits arrive least significant first on rising SCLK; the counter wraps to
  // zero after sixteen bits, and the completion flags below decide execution.
  always @(posedge clk) begin
    if (!rst_n) begin
      bitCnt <= 4'h0;
      frame  <= 16'h0000;
    end else if (!csActive) begin
      bitCnt <= 4'h0;
    end else if (sclkRise) begin
      frame[bitCnt] <= mosiSync[1];                  // see RULE24
      bitCnt        <= bitCnt + 4'h1;
    end
  end

  // Frames of a multiple of sixteen bits are flagged complete; a frame of other length is dropped.
  reg frameDone;
  always @(posedge clk) begin
    if (!rst_n) begin
      frameDone <= 1'b0;
    end else if (!csActive) begin
      frameDone <= 1'b0;
    end else if (sclkRise) begin
      frameDone <= (bitCnt == 4'hf);
    end
  end

  // A seventeenth rising edge marks the frame as too long; without it a frame of
  // thirty-two bits would wrap the counter and look complete a second time.
  reg frameLong;
  always @(posedge clk) begin
    if (!rst_n) begin
      frameLong <= 1'b0;
    end else if (!csActive) begin
      frameLong <= 1'b0;
    end else if (sclkRise && frameDone) begin
      frameLong <= 1'b1;                             // see RULE24
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Reserved and write-only bits are never stored, so they read as zero.
  // An unmapped address reads as zeros rather than as stale data.
  always @* begin
    case (rxAddr)
      `WBC_ADDR_HW_CTRL:  readData = hwCtrl;
      `WBC_ADDR_WDT_CTRL: readData = wdtCtrl & `WBC_WDT_STORE;        // see RULE6
      `WBC_ADDR_BUS_ONE:  readData = busOne & `WBC_BUS_ONE_STORE;     // see RULE16
      `WBC_ADDR_BUS_TWO:  readData = busTwo & `WBC_BUS_TWO_STORE;     // see RULE16
      default:            readData = 8'h00;
    endcase
  end

  // The data byte is latched once the address byte is complete; the first
  // byte returns zeros. MISO changes on falling SCLK for the next bit.
  always @(posedge clk) begin
    if (!rst_n) begin
      txByte  <= 8'h00;
      spiMiso <= 1'b0;
    end else if (!csActive) begin
      spiMiso <= 1'b0;
    end else begin
      if (sclkRise && bitCnt == 4'h7) begin
        txByte <= readData;
      end
      if (sclkFall) begin
        spiMiso <= bitCnt[3] ? txByte[bitCnt[2:0]] : 1'b0;
      end
    end
  end

  assign spiMisoOe = csActive;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  wire doWrite  = frameEnd & frameDone & ~frameLong & fullFrame;     // see RULE24
  wire hostHw   = doWrite & (rxAddr == `WBC_ADDR_HW_CTRL);
  wire hostWdt  = doWrite & (rxAddr == `WBC_ADDR_WDT_CTRL) & parityOk;   // see RULE5
  wire hostOne  = doWrite & (rxAddr == `WBC_ADDR_BUS_ONE);
  wire hostTwo  = doWrite & (rxAddr == `WBC_ADDR_BUS_TWO);
  wire devWdt   = hwWrite & (hwAddr == `WBC_ADDR_WDT_CTRL);
  wire devOne   = hwWrite & (hwAddr == `WBC_ADDR_BUS_ONE);
  wire devTwo   = hwWrite & (hwAddr == `WBC_ADDR_BUS_TWO);

  // Reset and soft reset load the power-on values, restart the restart values.
  // A device-side change of a hardware bit lands after a host write in the same
  // cycle, so the device's own update is never lost.
  always @(posedge clk) begin
    if (!rst_n || softReset) begin
      hwCtrl  <= `WBC_HW_RESET;
      wdtCtrl <= `WBC_WDT_RESET;                                      // see RULE20
      busOne  <= `WBC_BUS_ONE_RESET;                                  // see RULE21
      busTwo  <= `WBC_BUS_TWO_RESET;                                  // see RULE22
    end else if (restart) begin
      hwCtrl  <= hwCtrl & `WBC_HW_RST_KEEP;
      wdtCtrl <= (wdtCtrl & `WBC_WDT_RST_KEEP) | `WBC_WDT_RST_SET;    // see RULE20
      busOne  <= busOne & `WBC_BUS_ONE_KEEP;                          // see RULE21
      busTwo  <= busTwo & `WBC_BUS_TWO_KEEP;                          // see RULE22
    end else begin
      if (hostHw) begin
        hwCtrl <= rxData;
      end
      wdtCtrl <= devWdt ? ((hostWdt ? rxData : wdtCtrl) & ~`WBC_WDT_HW_MASK & `WBC_WDT_STORE)
                          | (hwData & `WBC_WDT_HW_MASK)               // see RULE23
               : (hostWdt ? (rxData & `WBC_WDT_STORE) : wdtCtrl);
      busOne  <= devOne ? ((hostOne ? rxData : busOne)
                          & ~`WBC_BUS_ONE_HW_MASK & `WBC_BUS_ONE_STORE)
                          | (hwData & `WBC_BUS_ONE_HW_MASK)           // see RULE23
               : (hostOne ? (rxData & `WBC_BUS_ONE_STORE) : busOne);
      busTwo  <= devTwo ? (hwData & `WBC_BUS_TWO_HW_MASK)             // see RULE23
               : (hostTwo ? (rxData & `WBC_BUS_TWO_STORE) : busTwo);
    end
  end

  // A rejected watchdog write raises a one-cycle failure pulse.
  // A pulse rather than a stored flag leaves the status register outside this block.
  always @(posedge clk) begin
    if (!rst_n) begin
      spiFail <= 1'b0;
    end else begin
      spiFail <= doWrite & (rxAddr == `WBC_ADDR_WDT_CTRL) & ~parityOk;  // see RULE5
    end
  end

  // --------------------------------------------------------------------------
  // Decoded outputs
  // --------------------------------------------------------------------------
  // Normal mode is shown to a transceiver as wake capable during low power,
  // while the stored field is left alone for the return to Normal mode.
  function [1:0] wbc_eff_mode;
    input [1:0] field;
    input       lp;
    begin
      wbc_eff_mode = (lp && field == `WBC_MODE_NORMAL) ? `WBC_MODE_WAKE : field;
    end
  endfunction

  // All decoded outputs are registered, so they follow the stored bits by one cycle.
  always @(posedge clk) begin
    if (!rst_n) begin
      boostLowSel        <= 1'b0;
      boostEnable        <= 1'b0;
      failoutSecondTrip  <= 1'b1;                                     // Hardware bit 0 resets clear.
      failSafeOnWdtFail  <= 1'b0;
      wdtActive          <= 1'b1;
      wdtWindowSel       <= 1'b0;
      wdtLongWindowStart <= 1'b0;
      wdtMaxThreeResets  <= 1'b0;
      wdtPeriod          <= 3'h4;
      wdtPeriodValid     <= 1'b1;
      linFlashMode       <= 1'b0;
      lowSlopeSel        <= 1'b0;
      txTimeoutEn        <= 1'b0;
      canMode            <= `WBC_MODE_OFF;
      linChAMode         <= `WBC_MODE_OFF;
      linChBMode         <= `WBC_MODE_OFF;
      linChCMode         <= `WBC_MODE_OFF;
      linChDMode         <= `WBC_MODE_OFF;
    end else begin
      boostLowSel        <= hwCtrl[`WBC_HW_BOOST_V];                  // see RULE1
      boostEnable        <= hwCtrl[`WBC_HW_BOOST_EN];                 // see RULE2
      failoutSecondTrip  <= ~hwCtrl[`WBC_HW_FAILOUT_CFG];             // see RULE3
      failSafeOnWdtFail  <= cfgSync;                                  // see RULE4
      wdtActive          <= ~(stopMode & wdtCtrl[`WBC_WDT_STOP_GATE]); // see RULE7
      wdtWindowSel       <= wdtCtrl[`WBC_WDT_WINDOW];                 // see RULE8
      wdtLongWindowStart <= busWake & stopMode & wdtCtrl[`WBC_WDT_BUS_WAKE]; // see RULE9
      wdtMaxThreeResets  <= wdtCtrl[`WBC_WDT_MAX3];                   // see RULE10
      wdtPeriod          <= wdtCtrl[`WBC_WDT_PERIOD_MSB:0];           // see RULE11
      wdtPeriodValid     <= (wdtCtrl[`WBC_WDT_PERIOD_MSB:0] != `WBC_PERIOD_RSVD);
      linFlashMode       <= busOne[`WBC_BUS_FLASH];                   // see RULE12
      lowSlopeSel        <= busOne[`WBC_BUS_LOW_SLOPE];               // see RULE13
      txTimeoutEn        <= busOne[`WBC_BUS_TX_TIMEOUT];              // see RULE14
      canMode            <= wbc_eff_mode(busOne[1:0], lowPower);      // see RULE15 RULE17
      linChAMode         <= wbc_eff_mode(busOne[4:3], lowPower);      // see RULE15 RULE17
      linChBMode         <= wbc_eff_mode(busTwo[1:0], lowPower);      // see RULE15 RULE17
      linChCMode         <= wbc_eff_mode(busTwo[4:3], lowPower);      // see RULE15 RULE17
      linChDMode         <= wbc_eff_mode(busTwo[7:6], lowPower);      // see RULE15 RULE17
    end
  end

endmodule

// ---- wbc_regs_asserts.sv ----
// Concurrent checks on the ports of the control register bank.
`timescale 1ns/1ns

module wbc_regs_asserts (
  input wire       clk,
  input wire       rst_n,
  input wire       spiCs_n,
  input wire       spiMisoOe,
  input wire       cfgPin,
  input wire       softReset,
  input wire       restart,
  input wire       stopMode,
  input wire       sleepMode,
  input wire       busWake,
  input wire       hwWrite,
  input wire       spiFail,
  input wire       failSafeOnWdtFail,
  input wire       wdtActive,
  input wire       wdtWindowSel,
  input wire       wdtLongWindowStart,
  input wire       wdtMaxThreeResets,
  input wire [2:0] wdtPeriod,
  input wire       wdtPeriodValid,
  input wire       linFlashMode,
  input wire [1:0] canMode,
  input wire [1:0] linChAMode,
  input wire [1:0] linChBMode,
  input wire [1:0] linChCMode,
  input wire [1:0] linChDMode
);
  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Low-power substitution is checked two cycles in, since the mode level feeds a register.
  a_lp_no_normal: assert property (
    $past(stopMode || sleepMode) && $past(stopMode || sleepMode, 2)
    |-> canMode != 2'h3 && linChAMode != 2'h3 && linChBMode != 2'h3 && linChCMode != 2'h3
    && linChDMode != 2'h3) else $error("normal mode seen in low power");
  a_fail_pulse_once: assert property (
    spiFail |-> $past(spiCs_n) ##1 !spiFail)
    else $error("parity fail pulse malformed");
  a_period_valid_code: assert property (
    wdtPeriodValid == (wdtPeriod != 3'h7))
    else $error("period valid flag wrong");
  a_wake_restart_cause: assert property (
    wdtLongWindowStart |-> $past(busWake && stopMode))
    else $error("long window without stop wake");
  a_active_out_stop: assert property (
    $past(!stopMode) && $past(!stopMode, 2) |-> wdtActive)
    else $error("watchdog inactive outside stop");
  a_select_enables_miso: assert property (
    (!spiCs_n)[*4] |-> spiMisoOe)
    else $error("miso not enabled in frame");
  a_cfg_pin_follow: assert property (
    $stable(cfgPin)[*4] |-> failSafeOnWdtFail == cfgPin)
    else $error("config pin not followed");
  a_reset_out_values: assert property (
    $rose(rst_n) |-> wdtPeriod == 3'h4 && wdtActive)
    else $error("outputs wrong after reset");
  a_soft_reset_load: assert property (
    softReset && !hwWrite |-> ##2 wdtPeriod == 3'h4
    && !wdtWindowSel && !linFlashMode && canMode == 2'h0)
    else $error("soft reset values wrong");
  a_restart_wdt_load: assert property (
    restart && !softReset && !hwWrite |-> ##2
    wdtPeriod == 3'h4 && !wdtWindowSel && !wdtMaxThreeResets)
    else $error("restart values wrong");

  // Main scenarios reached.
  c_parity_fail: cover property (spiFail);
  c_long_window: cover property (wdtLongWindowStart);
  c_restart_seen: cover property (restart);
endmodule

bind wbc_regs wbc_regs_asserts chk_u (
  .clk(clk), .rst_n(rst_n), .spiCs_n(spiCs_n), .spiMisoOe(spiMisoOe), .cfgPin(cfgPin),
  .softReset(softReset), .restart(restart), .stopMode(stopMode), .sleepMode(sleepMode),
  .busWake(busWake), .hwWrite(hwWrite), .spiFail(spiFail),
  .failSafeOnWdtFail(failSafeOnWdtFail), .wdtActive(wdtActive),
  .wdtWindowSel(wdtWindowSel), .wdtLongWindowStart(wdtLongWindowStart),
  .wdtMaxThreeResets(wdtMaxThreeResets), .wdtPeriod(wdtPeriod),
  .wdtPeriodValid(wdtPeriodValid), .linFlashMode(linFlashMode), .canMode(canMode),
  .linChAMode(linChAMode), .linChBMode(linChBMode), .linChCMode(linChCMode),
  .linChDMode(linChDMode));

// ---- wbc_regs_map.vh ----
// Register offsets, field positions, reset and restart values of the control registers.
`ifndef WBC_REGS_MAP_VH
`define WBC_REGS_MAP_VH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define WBC_FRAME_BITS      16
`define WBC_ACCESS_BIT      7
`define WBC_DATA_LSB        8

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define WBC_ADDR_HW_CTRL    7'h02
`define WBC_ADDR_WDT_CTRL   7'h03
`define WBC_ADDR_BUS_ONE    7'h04
`define WBC_ADDR_BUS_TWO    7'h05

// ----------------------------------------------------------------------------
// Reset values, restart clear masks and restart set values
// ----------------------------------------------------------------------------
`define WBC_HW_RESET        8'h00
`define WBC_WDT_RESET       8'h14
`define WBC_BUS_ONE_RESET   8'h20
`define WBC_BUS_TWO_RESET   8'h00
`define WBC_HW_RST_KEEP     8'hdf
`define WBC_WDT_RST_KEEP    8'h10
`define WBC_WDT_RST_SET     8'h04
`define WBC_BUS_ONE_KEEP    8'hfb
`define WBC_BUS_TWO_KEEP    8'hdb

// ----------------------------------------------------------------------------
// Storable bits and bits the device logic may also change
// ----------------------------------------------------------------------------
`define WBC_WDT_STORE       8'h7f
`define WBC_BUS_ONE_STORE   8'hfb
`define WBC_BUS_TWO_STORE   8'hdb
`define WBC_WDT_HW_MASK     8'h57
`define WBC_BUS_ONE_HW_MASK 8'h1b
`define WBC_BUS_TWO_HW_MASK 8'hdb

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WBC_HW_BOOST_V      2
`define WBC_HW_BOOST_EN     1
`define WBC_HW_FAILOUT_CFG  0
`define WBC_WDT_STOP_GATE   6
`define WBC_WDT_WINDOW      5
`define WBC_WDT_BUS_WAKE    4
`define WBC_WDT_MAX3        3
`define WBC_WDT_PERIOD_MSB  2
`define WBC_BUS_FLASH       7
`define WBC_BUS_LOW_SLOPE   6
`define WBC_BUS_TX_TIMEOUT  5

// ----------------------------------------------------------------------------
// Transceiver mode codes and reserved watchdog period
// ----------------------------------------------------------------------------
`define WBC_MODE_OFF        2'h0
`define WBC_MODE_WAKE       2'h1
`define WBC_MODE_RX_ONLY    2'h2
`define WBC_MODE_NORMAL     2'h3
`define WBC_PERIOD_RSVD     3'h7

`endif

// ---- wbc_spi_host.sv ----
// Host controller model that issues SPI frames of a chosen bit count to the register bank.
`timescale 1ns/1ns

module wbc_spi_host (
  input  wire clk,
  input  wire spiMiso,
  output reg  spiCs_n,
  output reg  spiSclk,
  output reg  spiMosi
);
  // Idle bus: deselected, clock parked low, so the bank sees no stray edges.
  initial begin
    spiCs_n = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end

  // Address, access bit then data, least significant first; phases of five cycles
  // leave margin over the bank's two-flop sampling.
  task automatic frame(input [15:0] tx, input integer nbits, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      @(negedge clk) spiCs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < nbits; i = i + 1) begin
        spiMosi = tx[i % 16];
        repeat (5) @(negedge clk);
        if (i >= 8 && i < 16) rx[i - 8] = spiMiso;
        spiSclk = 1'b1;
        repeat (5) @(negedge clk);
        spiSclk = 1'b0;
      end
      repeat (5) @(negedge clk);
      spiCs_n = 1'b1;
      repeat (8) @(negedge clk);
    end
  endtask
endmodule
